// *** hw/rtc_map.svh ***
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// register byte offsets
`define RTC_AW 12
`define RTC_OFF_CTRL 12'h000
`define RTC_OFF_DEBUG 12'h004
`define RTC_OFF_MASK 12'h008
`define RTC_OFF_FLAGS 12'h00c
`define RTC_OFF_COUNT 12'h010
`define RTC_OFF_COMPARE_VALUE_ZERO 12'h014
`define RTC_OFF_COMP1 12'h018
`define RTC_OFF_TOP 12'h01c
`define RTC_OFF_CLOCK 12'h020

// control and debug fields
`define RTC_CTRL_SOFT_RESET_BIT 0
`define RTC_CTRL_EN 1
`define RTC_CTRL_MODE 3:2
`define RTC_CTRL_MCLR 7
`define RTC_DBG_RUN 0

// mode codes
`define RTC_MODE_C32 2'h0
`define RTC_MODE_C16 2'h1
`define RTC_MODE_CAL 2'h2
`define RTC_MODE_OFF 2'h3

// flag positions
`define RTC_NFLAGS 3
`define RTC_FLG_WRAP 0
`define RTC_FLG_M0 1
`define RTC_FLG_M1 2

// reset and limit values
`define RTC_ZERO32 32'h00000000
`define RTC_ONE32 32'h00000001
`define RTC_TOP32 32'hffffffff
`define RTC_ZERO16 16'h0000
`define RTC_ONE16 16'h0001
`define RTC_TOP_RST 16'hffff

// calendar word layout
`define RTC_SEC_F 5:0
`define RTC_MIN_F 11:6
`define RTC_HR_F 16:12
`define RTC_DAY_F 31:17
`define RTC_SEC_MAX 6'h3b
`define RTC_MIN_MAX 6'h3b
`define RTC_HR_MAX 5'h17
`define RTC_ONE6 6'h01
`define RTC_ONE5 5'h01
`define RTC_ONE_DAY 16'h0001

`endif

// *** hw/rtc_pkg.sv ***
`include "rtc_map.svh"
package rtc_pkg;

    typedef enum logic [1:0] {
        MODE_COUNT32 = `RTC_MODE_C32,
        MODE_COUNT16 = `RTC_MODE_C16,
        MODE_CALENDAR = `RTC_MODE_CAL,
        MODE_STOPPED = `RTC_MODE_OFF
    } mode_t;

    typedef struct packed {
        logic match_clear;
        mode_t mode;
        logic enable;
    } ctrl_t;

    typedef logic [`RTC_NFLAGS-1:0] flags_t;

    typedef struct packed {
        logic [31:0] compare_value_zero;
        logic [31:0] comp1;
        logic [15:0] top;
    } cmp_set_t;

endpackage

// *** hw/tick_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module tick_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous tick pin
    input wire logic tick_pin,
    // one pclk pulse per rising tick edge
    output logic tick_rise
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser; only sync_reg and last_reg feed the detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= tick_pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // registered edge pulse, tick must be slower than pclk / 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_rise <= 1'b0;
        end else begin
            tick_rise <= sync_reg & ~last_reg;
        end
    end

endmodule
`default_nettype wire

// *** hw/irq_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_flags (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_clear,
    // hardware events
    input wire rtc_pkg::flags_t set_bits,
    // software clear (write one) and mask write
    input wire logic clr_we,
    input wire rtc_pkg::flags_t clr_bits,
    input wire logic mask_we,
    input wire rtc_pkg::flags_t mask_bits,
    // state
    output rtc_pkg::flags_t status,
    output rtc_pkg::flags_t mask,
    output logic irq
);

    rtc_pkg::flags_t status_next;
    rtc_pkg::flags_t mask_next;

    ////////////////////////////////////////////////////////////////////////
    // set beats clear so an event in the clearing cycle is kept
    always_comb begin
        status_next = status;
        mask_next = mask;
        if (clr_we) begin
            status_next = status & ~clr_bits;
        end
        status_next = status_next | set_bits;
        if (mask_we) begin
            mask_next = mask_bits;
        end
    end

    // soft reset wipes flags and mask along with the rest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            mask <= '0;
            irq <= 1'b0;
        end else if (soft_clear) begin
            status <= '0;
            mask <= '0;
            irq <= 1'b0;
        end else begin
            status <= status_next;
            mask <= mask_next;
            irq <= |(status_next & mask_next);
        end
    end

endmodule
`default_nettype wire

// *** hw/rtc_counter_modes.sv ***
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"
module rtc_counter_modes (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RTC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // count tick pin, asynchronous to pclk
    input wire logic count_tick_clock,
    // debugger halt from same-clock logic
    input wire logic debug_halt,
    // level interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    rtc_pkg::ctrl_t ctrl_reg;
    rtc_pkg::cmp_set_t cmp_reg;
    logic dbg_run_reg;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [31:0] rdata_next;
    logic err_next;
    rtc_pkg::flags_t flag_set;
    rtc_pkg::flags_t irq_status;
    rtc_pkg::flags_t irq_mask;
    logic tick_rise;
    logic run;
    logic step;
    logic hit0;
    logic hit1;
    logic narrow;
    logic [32:0] cal_sum;

    // bus decode strobes
    logic setup;
    logic wr;
    logic wr_ctrl;
    logic wr_count;
    logic soft_rst;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // compare, low half only when counting in 16 bits
    function automatic logic is_match(input logic [31:0] v,
                                      input logic [31:0] c,
                                      input logic half);
        logic r;
        r = half ? (v[15:0] == c[15:0]) : (v == c);
        return r;
    endfunction

    // calendar step; the top bit is the carry out of the day field
    function automatic logic [32:0] cal_step(input logic [31:0] v);
        logic [31:0] n;
        logic c;
        n = v;
        c = 1'b0;
        if (v[`RTC_SEC_F] < `RTC_SEC_MAX) begin
            n[`RTC_SEC_F] = v[`RTC_SEC_F] + `RTC_ONE6;
        end else begin
            n[`RTC_SEC_F] = '0;
            if (v[`RTC_MIN_F] < `RTC_MIN_MAX) begin
                n[`RTC_MIN_F] = v[`RTC_MIN_F] + `RTC_ONE6;
            end else begin
                n[`RTC_MIN_F] = '0;
                if (v[`RTC_HR_F] < `RTC_HR_MAX) begin
                    n[`RTC_HR_F] = v[`RTC_HR_F] + `RTC_ONE5;
                end else begin
                    n[`RTC_HR_F] = '0;
                    {c, n[`RTC_DAY_F]} = {1'b0, v[`RTC_DAY_F]}
                        + `RTC_ONE_DAY;
                end
            end
        end
        return {c, n};
    endfunction

    // view of the count as software sees it in the current mode
    function automatic logic [31:0] count_view(input logic [31:0] v,
                                               input logic half);
        logic [31:0] r;
        r = half ? {`RTC_ZERO16, v[15:0]} : v;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // tick synchroniser and interrupt flags

    tick_sync u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick_pin(count_tick_clock),
        .tick_rise(tick_rise)
    );

    irq_flags u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .soft_clear(soft_rst),
        .set_bits(flag_set),
        .clr_we(wr && paddr == `RTC_OFF_FLAGS),
        .clr_bits(pwdata[`RTC_NFLAGS-1:0]),
        .mask_we(wr && paddr == `RTC_OFF_MASK),
        .mask_bits(pwdata[`RTC_NFLAGS-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus strobes; zero wait states, writes land at the access edge

    assign pready = 1'b1;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign wr_ctrl = wr && paddr == `RTC_OFF_CTRL;
    assign wr_count = wr && (paddr == `RTC_OFF_COUNT ||
                             paddr == `RTC_OFF_CLOCK);
    assign soft_rst = wr_ctrl & pwdata[`RTC_CTRL_SOFT_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////
    // run gating: the debugger may freeze the count unless told not to

    assign run = ctrl_reg.enable & (~debug_halt | dbg_run_reg);
    assign step = tick_rise & run;
    assign narrow = ctrl_reg.mode == rtc_pkg::MODE_COUNT16;
    assign hit0 = is_match(count_reg, cmp_reg.compare_value_zero, narrow);
    assign hit1 = is_match(count_reg, cmp_reg.comp1, narrow);
    assign cal_sum = cal_step(count_reg);

    ////////////////////////////////////////////////////////////////////////
    // counting step and flag events, evaluated on count ticks only;
    // a match seen on the current value raises its flag with the tick

    always_comb begin
        count_next = count_reg;
        flag_set = '0;
        if (step) begin
            unique case (ctrl_reg.mode)
                rtc_pkg::MODE_COUNT32: begin
                    if (ctrl_reg.match_clear && hit0) begin
                        count_next = `RTC_ZERO32;
                        flag_set[`RTC_FLG_WRAP] = 1'b1;
                        flag_set[`RTC_FLG_M0] = 1'b1;
                    end else begin
                        count_next = count_reg + `RTC_ONE32;
                        if (count_reg == `RTC_TOP32) begin
                            flag_set[`RTC_FLG_WRAP] = 1'b1;
                        end
                        flag_set[`RTC_FLG_M0] = hit0;
                    end
                end
                rtc_pkg::MODE_COUNT16: begin
                    if (count_reg[15:0] == cmp_reg.top) begin
                        count_next = `RTC_ZERO32;
                        flag_set[`RTC_FLG_WRAP] = 1'b1;
                    end else begin
                        count_next = {`RTC_ZERO16,
                                      count_reg[15:0] + `RTC_ONE16};
                    end
                    flag_set[`RTC_FLG_M0] = hit0;
                    flag_set[`RTC_FLG_M1] = hit1;
                end
                rtc_pkg::MODE_CALENDAR: begin
                    count_next = cal_sum[31:0];
                    flag_set[`RTC_FLG_WRAP] = cal_sum[32];
                    flag_set[`RTC_FLG_M0] = hit0;
                end
                rtc_pkg::MODE_STOPPED: begin
                    // reserved code: value holds, nothing flags
                    count_next = count_reg;
                end
            endcase
        end
        // software write wins over a tick in the same cycle
        if (wr_count) begin
            count_next = count_view(pwdata, narrow);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register; soft reset returns it to zero, block disabled

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
        end else if (soft_rst) begin
            ctrl_reg <= '0;
        end else if (wr_ctrl) begin
            ctrl_reg.enable <= pwdata[`RTC_CTRL_EN];
            ctrl_reg.mode <= rtc_pkg::mode_t'(pwdata[`RTC_CTRL_MODE]);
            ctrl_reg.match_clear <= pwdata[`RTC_CTRL_MCLR];
        end
    end

    // debug control survives soft reset by design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_run_reg <= 1'b0;
        end else if (wr && paddr == `RTC_OFF_DEBUG) begin
            dbg_run_reg <= pwdata[`RTC_DBG_RUN];
        end
    end

    // compare values and the 16-bit top limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_reg.compare_value_zero <= `RTC_ZERO32;
            cmp_reg.comp1 <= `RTC_ZERO32;
            cmp_reg.top <= `RTC_TOP_RST;
        end else if (soft_rst) begin
            cmp_reg.compare_value_zero <= `RTC_ZERO32;
            cmp_reg.comp1 <= `RTC_ZERO32;
            cmp_reg.top <= `RTC_TOP_RST;
        end else if (wr) begin
            if (paddr == `RTC_OFF_COMPARE_VALUE_ZERO) begin
                cmp_reg.compare_value_zero <= pwdata;
            end
            if (paddr == `RTC_OFF_COMP1) begin
                cmp_reg.comp1 <= pwdata;
            end
            if (paddr == `RTC_OFF_TOP) begin
                cmp_reg.top <= pwdata[15:0];
            end
        end
    end

    // the counter itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `RTC_ZERO32;
        end else if (soft_rst) begin
            count_reg <= `RTC_ZERO32;
        end else begin
            count_reg <= count_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, sampled in the setup phase so prdata is a flop output;
    // unmapped addresses answer zero with an error

    always_comb begin
        rdata_next = `RTC_ZERO32;
        err_next = 1'b0;
        unique case (paddr)
            `RTC_OFF_CTRL: begin
                rdata_next[`RTC_CTRL_EN] = ctrl_reg.enable;
                rdata_next[`RTC_CTRL_MODE] = ctrl_reg.mode;
                rdata_next[`RTC_CTRL_MCLR] = ctrl_reg.match_clear;
            end
            `RTC_OFF_DEBUG: rdata_next[`RTC_DBG_RUN] = dbg_run_reg;
            `RTC_OFF_MASK: rdata_next[`RTC_NFLAGS-1:0] = irq_mask;
            `RTC_OFF_FLAGS: rdata_next[`RTC_NFLAGS-1:0] = irq_status;
            `RTC_OFF_COUNT,
            `RTC_OFF_CLOCK: begin
                rdata_next = count_view(count_reg, narrow);
            end
            `RTC_OFF_COMPARE_VALUE_ZERO: rdata_next = cmp_reg.compare_value_zero;
            `RTC_OFF_COMP1: rdata_next = cmp_reg.comp1;
            `RTC_OFF_TOP: rdata_next[15:0] = cmp_reg.top;
            default: err_next = 1'b1;
        endcase
    end

    // a read captured in setup may miss a tick landing one cycle later;
    // software that needs an exact value reads twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `RTC_ZERO32;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? `RTC_ZERO32 : rdata_next;
            pslverr <= err_next;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** dv/rtc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"
module rtc_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RTC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic count_tick_clock,
    input wire logic debug_halt,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] since_tick;
    logic [3:0] since_wr;
    logic acc, wr, bad;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    // misaligned words decode to nothing, so they count as unmapped too
    assign bad = paddr > `RTC_OFF_CLOCK || paddr[1:0] != 2'h0;
    // age of the last tick rise; saturates so a long idle never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_tick <= 4'hf;
        end else if ($rose(count_tick_clock)) begin
            since_tick <= 4'h0;
        end else if (since_tick != 4'hf) begin
            since_tick <= since_tick + 4'h1;
        end
    end
    // age of the last register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_wr <= 4'hf;
        end else if (wr) begin
            since_wr <= 4'h0;
        end else if (since_wr != 4'hf) begin
            since_wr <= since_wr + 4'h1;
        end
    end
    ////////////////////////////////////////
    ready_high_a: assert property (pready)
        else $error("pready low");
    bad_addr_err_a: assert property (acc && bad |-> pslverr)
        else $error("no error on unmapped access");
    good_addr_ok_a: assert property (acc && !bad |-> !pslverr)
        else $error("error on mapped access");
    bad_read_zero_a: assert property (
        acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    read_hold_a: assert property (acc && !pwrite |=> $stable(prdata))
        else $error("read data moved after access");
    err_idle_a: assert property (!psel ##1 !psel |-> !pslverr)
        else $error("error flag high while idle");
    irq_cause_a: assert property (
        $rose(irq) |-> since_tick <= 4'ha || since_wr <= 4'h3)
        else $error("interrupt rose with no tick or write");
    flag_clear_a: assert property (
        wr && paddr == 12'h00c && pwdata[2:0] == 3'h7 && since_tick > 4'hb
        |-> ##[1:2] !irq)
        else $error("interrupt stays after clearing all flags");
    mask_off_a: assert property (
        wr && paddr == 12'h008 && pwdata[2:0] == 3'h0 |-> ##[1:2] !irq)
        else $error("interrupt stays with all masked");
    soft_rst_a: assert property (
        wr && paddr == 12'h000 && pwdata[0] |-> ##[1:2] !irq)
        else $error("interrupt stays after soft reset");
endmodule
`default_nettype wire

// *** dv/rtc_counter_modes_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"
module rtc_counter_modes_test;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } row_t;
    logic pclk, presetn, psel, penable, pwrite;
    logic [`RTC_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, count_tick_clock, debug_halt, irq, e;
    int error_cnt = 0;
    int samples_checked = 0;
    // write then read back; mode 1 shows only the low half of the count
    row_t rows [0:9] = '{
        '{12'h004, 32'h00000001, 32'h00000001, 1'b0},
        '{12'h008, 32'h00000007, 32'h00000007, 1'b0},
        '{12'h014, 32'h12345678, 32'h12345678, 1'b0},
        '{12'h018, 32'h0000abcd, 32'h0000abcd, 1'b0},
        '{12'h01c, 32'h00001234, 32'h00001234, 1'b0},
        '{12'h010, 32'hdeadbeef, 32'hdeadbeef, 1'b0},
        '{12'h000, 32'h00000004, 32'h00000004, 1'b0},
        '{12'h010, 32'h12345678, 32'h00005678, 1'b0},
        '{12'h100, 32'h5a5a5a5a, 32'h00000000, 1'b1},
        '{12'h011, 32'h5a5a5a5a, 32'h00000000, 1'b1}};
    // reset contents, debug excluded since soft reset keeps it
    logic [11:0] rst_addr [0:6] = '{12'h000, 12'h008, 12'h00c, 12'h010,
        12'h014, 12'h018, 12'h01c};
    logic [31:0] rst_val [0:6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0000ffff};

    rtc_counter_modes i_rtc_counter_modes (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .count_tick_clock(count_tick_clock), .debug_halt(debug_halt),
        .irq(irq));
    ////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] y);
        samples_checked++;
        if (y !== x) begin
            $display("BAD %s expected %h seen %h", nm, x, y);
            error_cnt++;
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input string nm);
        apb(a, 1'b0, 32'h0);
        chk(nm, x, q);
    endtask
    // irq is a flop loaded with the flags from their next value, so let two edges pass first
    task automatic irq_chk(input logic x, input string nm);
        repeat (2) @(posedge pclk);
        chk(nm, {31'h0, x}, {31'h0, irq});
    endtask
    // pin high and low long enough for the synchroniser to see it
    task automatic tick();
        count_tick_clock <= 1'b1;
        repeat (4) @(posedge pclk);
        count_tick_clock <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    task automatic rst_chk();
        for (int i = 0; i < 7; i++) begin
            rd(rst_addr[i], rst_val[i], "reset value");
        end
    endtask
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #125000;
        error_cnt++;
        close_out();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        count_tick_clock = 1'b0;
        debug_halt = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata, "row read");
            chk("row error", {31'h0, rows[i].err}, {31'h0, e});
        end
        $display("table test done");
        wr(12'h000, 32'h0);
        wr(12'h010, 32'h5);
        wr(12'h014, 32'h7);
        wr(12'h00c, 32'h7);
        wr(12'h000, 32'h82);
        repeat (2) tick();
        rd(12'h010, 32'h7, "count at hit");
        rd(12'h00c, 32'h0, "flags before hit");
        tick();
        rd(12'h010, 32'h0, "count after hit");
        rd(12'h00c, 32'h3, "flags after hit");
        $display("clear on match test done");
        wr(12'h000, 32'h0);
        wr(12'h00c, 32'h7);
        wr(12'h008, 32'h0);
        wr(12'h010, 32'hfffffffe);
        wr(12'h000, 32'h2);
        tick();
        rd(12'h00c, 32'h0, "flags at top");
        tick();
        rd(12'h010, 32'h0, "count after wrap");
        rd(12'h00c, 32'h1, "wrap flag");
        irq_chk(1'b0, "irq masked");
        wr(12'h008, 32'h1);
        irq_chk(1'b1, "irq unmasked");
        wr(12'h00c, 32'h1);
        irq_chk(1'b0, "irq cleared");
        $display("wrap test done");
        wr(12'h000, 32'h0);
        wr(12'h010, 32'h10);
        wr(12'h014, 32'h10);
        tick();
        rd(12'h010, 32'h10, "count disabled");
        rd(12'h00c, 32'h0, "flags disabled");
        wr(12'h000, 32'he);
        tick();
        rd(12'h010, 32'h10, "count mode 3");
        rd(12'h00c, 32'h0, "flags mode 3");
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h2);
        debug_halt <= 1'b1;
        tick();
        rd(12'h010, 32'h10, "count halted");
        debug_halt <= 1'b0;
        tick();
        rd(12'h010, 32'h11, "count resumed");
        rd(12'h00c, 32'h2, "match flag");
        $display("hold test done");
        wr(12'h000, 32'h0);
        wr(12'h00c, 32'h7);
        wr(12'h010, 32'h0);
        wr(12'h01c, 32'h2);
        wr(12'h014, 32'h1);
        wr(12'h018, 32'h2);
        wr(12'h000, 32'h6);
        repeat (2) tick();
        rd(12'h00c, 32'h2, "first match 16");
        tick();
        rd(12'h010, 32'h0, "count wrap 16");
        rd(12'h00c, 32'h7, "flags 16");
        $display("mode 1 test done");
        wr(12'h000, 32'h0);
        wr(12'h014, 32'hffffffff);
        wr(12'h020, 32'h00000efb);
        wr(12'h000, 32'ha);
        tick(); // one tick stands for one second
        rd(12'h020, 32'h00001000, "calendar step");
        $display("calendar test done");
        wr(12'h000, 32'h0);
        wr(12'h004, 32'h1);
        wr(12'h008, 32'h7);
        wr(12'h000, 32'h1);
        rst_chk();
        rd(12'h004, 32'h1, "debug kept");
        irq_chk(1'b0, "irq after soft reset");
        $display("soft reset test done");
        close_out();
    end
endmodule
bind rtc_counter_modes rtc_monitor i_rtc_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_tick_clock(count_tick_clock),
    .debug_halt(debug_halt), .irq(irq));
`default_nettype wire
